// *** shared/ccau_pkg.sv ***
package ccau_pkg;
    // Geometry
    localparam int NCH = 16;
    localparam int TW = 16;
    // Register offsets (byte addresses, one 32-bit word each)
    localparam logic [9:0] A_T0 = 10'h000;
    localparam logic [9:0] A_T0_REL = 10'h004;
    localparam logic [9:0] A_T1 = 10'h008;
    localparam logic [9:0] A_T1_REL = 10'h00c;
    localparam logic [9:0] A_TCTL = 10'h010;
    localparam logic [9:0] A_IRQ_STAT = 10'h014;
    localparam logic [9:0] A_IRQ_MASK = 10'h018;
    localparam logic [9:0] A_STAGGER = 10'h01c;
    localparam logic [9:0] A_CH_MODE = 10'h040;
    localparam logic [9:0] A_CH_VAL = 10'h080;
    // Timer control fields per timer (byte lane t): run, clock source
    localparam int TC_RUN = 0;
    localparam int TC_SRC_LSB = 1;
    localparam int TC_W = 8;
    // Channel mode fields
    localparam int CM_FUNC_LSB = 0;
    localparam int CM_EDGE_LSB = 3;
    localparam int CM_TSEL = 5;
    localparam int CM_SINGLE = 6;
    localparam int CM_DOUBLE = 7;
    // Reset values
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'h00;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int STAGGER_DIV = 8;

    // Channel function codes
    typedef enum logic [2:0] {
        CCAU_OFF = 3'h0,
        CCAU_CAP = 3'h1,
        CCAU_CMP0 = 3'h2,
        CCAU_CMP1 = 3'h3,
        CCAU_CMP2 = 3'h4,
        CCAU_CMP3 = 3'h5
    } ccau_func_t;

    // Count clock source codes
    typedef enum logic [2:0] {
        CCAU_DIV8 = 3'h0,
        CCAU_DIV16 = 3'h1,
        CCAU_DIV32 = 3'h2,
        CCAU_DIV64 = 3'h3,
        CCAU_GPT = 3'h4,
        CCAU_EXT = 3'h5
    } ccau_src_t;

    typedef struct packed {
        logic double_en;
        logic single_en;
        logic tsel;
        logic [1:0] edge_sel;
        ccau_func_t func;
    } ccau_mode_t;

    // Timer broadcast to channels
    typedef struct packed {
        logic [1:0] tick;
        logic [1:0] ovf;
        logic [TW-1:0] cnt0;
        logic [TW-1:0] cnt1;
    } ccau_tbus_t;
endpackage

// *** hw/ccau_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccau_timer
#(
    parameter int W = 16
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic tick_i,
    input wire logic wr_cnt_i,
    input wire logic wr_rel_i,
    input wire logic [W-1:0] wdata_i,
    // State
    output logic [W-1:0] cnt_o,
    output logic [W-1:0] rel_o,
    output logic ovf_o
)
;
    logic [W-1:0] cnt_r;
    logic [W-1:0] rel_r;
    logic ovf_r;
    wire wrap = tick_i && (cnt_r == {W{1'b1}});

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
            rel_r <= '0;
            ovf_r <= 1'b0;
        end
        else
        begin
            ovf_r <= wrap;
            if (wr_rel_i)
                rel_r <= wdata_i;
            if (wr_cnt_i)
                cnt_r <= wdata_i;
            else if (wrap)
                cnt_r <= rel_r;
            else if (tick_i)
                cnt_r <= cnt_r + 1'b1;
        end
    end
    assign cnt_o = cnt_r;
    assign rel_o = rel_r;
    assign ovf_o = ovf_r;

    reload_chk_a: assert property (@(posedge clk_i)
        disable iff (rst_i) wrap && !wr_cnt_i |=> cnt_r == $past(rel_r))
        else $error("timer did not reload");
endmodule
`default_nettype wire

// *** hw/ccau_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccau_chan
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration
    input wire ccau_pkg::ccau_mode_t mode_i,
    input wire logic [15:0] val_i,
    input wire logic wr_val_i,
    input wire logic arm_i,
    // Timers
    input wire ccau_pkg::ccau_tbus_t tb_i,
    // Pin, already synchronised
    input wire logic pin_i,
    // Results
    output logic [15:0] reg_o,
    output logic event_o,
    output logic toggle_o,
    output logic set_o,
    output logic clr_o
)
;
    logic [15:0] reg_r;
    logic pin_d_r;
    logic done_r;
    logic fired_r;
    wire [15:0] tcnt = mode_i.tsel ? tb_i.cnt1 : tb_i.cnt0;
    wire ttick = tb_i.tick[mode_i.tsel];
    wire tovf = tb_i.ovf[mode_i.tsel];
    wire is_cap = mode_i.func == ccau_pkg::CCAU_CAP;
    // Unused function codes stay silent instead of raising events
    wire is_cmp = mode_i.func >= ccau_pkg::CCAU_CMP0 &&
        mode_i.func <= ccau_pkg::CCAU_CMP3;
    wire rise = pin_i && !pin_d_r;
    wire fall = !pin_i && pin_d_r;
    wire cap_hit = is_cap && ((mode_i.edge_sel[0] && rise) ||
        (mode_i.edge_sel[1] && fall));
    wire match = is_cmp && ttick && (tcnt == reg_r);
    wire once = mode_i.func == ccau_pkg::CCAU_CMP2 ||
        mode_i.func == ccau_pkg::CCAU_CMP3;
    wire cmp_hit = match && !(once && fired_r) &&
        !(mode_i.single_en && done_r);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_r <= '0;
            pin_d_r <= 1'b0;
            done_r <= 1'b0;
            fired_r <= 1'b0;
        end
        else
        begin
            pin_d_r <= pin_i;
            if (cap_hit)
                reg_r <= tcnt;
            else if (wr_val_i)
                reg_r <= val_i;
            if (arm_i)
                done_r <= 1'b0;
            else if (cmp_hit)
                done_r <= 1'b1;
            if (tovf)
                fired_r <= 1'b0;
            else if (cmp_hit)
                fired_r <= 1'b1;
        end
    end

    assign reg_o = reg_r;
    assign event_o = cap_hit || cmp_hit;
    assign toggle_o = cmp_hit && (mode_i.func == ccau_pkg::CCAU_CMP1 ||
        mode_i.double_en);
    assign set_o = cmp_hit && mode_i.func == ccau_pkg::CCAU_CMP3 &&
        !mode_i.double_en;
    assign clr_o = tovf && mode_i.func == ccau_pkg::CCAU_CMP3 &&
        !mode_i.double_en && !(mode_i.single_en && done_r && !fired_r);

    cap_copy_a: assert property (@(posedge clk_i)
        disable iff (rst_i) cap_hit |=> reg_r == $past(tcnt))
        else $error("capture value wrong");
    once_per_a: assert property (@(posedge clk_i)
        disable iff (rst_i) fired_r && once && !tovf |-> !event_o && !set_o)
        else $error("second event in one period");
endmodule
`default_nettype wire

// *** hw/ccau_top.sv ***
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ccau_top
#(
    parameter int NCH = ccau_pkg::NCH
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Count sources
    input wire logic gpt_ovf_i,
    input wire logic [1:0] ext_cnt_i,
    // Channel pins
    input wire logic [NCH-1:0] pin_i,
    output logic [NCH-1:0] pin_o,
    output logic [NCH-1:0] pin_oe_o,
    // Interrupt
    output logic irq_o
)
;
    localparam int TW = ccau_pkg::TW;

    logic [NCH-1:0] pin_s1_r;
    logic [NCH-1:0] pin_s2_r;
    logic [1:0] ext_s1_r;
    logic [1:0] ext_s2_r;
    logic [1:0] ext_d_r;
    logic gpt_d_r;
    logic [5:0] pre_r;
    logic [2:0] stag_r;
    logic stagger_r;
    logic [15:0] tctl_r;
    logic [NCH-1:0] stat_r;
    logic [NCH-1:0] mask_r;
    logic [NCH-1:0] pin_r;
    logic [NCH-1:0] oe_r;
    logic irq_r;
    logic ack_r;
    logic [31:0] rdat_r;
    ccau_pkg::ccau_mode_t mode_r [NCH];

    // Bus decode
    wire req = wb_cyc_i && wb_stb_i && !ack_r;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire rd = req && !wb_we_i;
    wire [3:0] ch_idx = wb_adr_i[5:2];
    wire in_mode = wb_adr_i[9:6] == ccau_pkg::A_CH_MODE[9:6];
    wire in_val = wb_adr_i[9:6] == ccau_pkg::A_CH_VAL[9:6];
    wire wr_t0 = wr && wb_adr_i == ccau_pkg::A_T0;
    wire wr_r0 = wr && wb_adr_i == ccau_pkg::A_T0_REL;
    wire wr_t1 = wr && wb_adr_i == ccau_pkg::A_T1;
    wire wr_r1 = wr && wb_adr_i == ccau_pkg::A_T1_REL;
    wire rd_stat = rd && wb_adr_i == ccau_pkg::A_IRQ_STAT;

    wire stag_ok = !stagger_r || stag_r == 3'(ccau_pkg::STAGGER_DIV - 1);
    wire [TW-1:0] cnt0;
    wire [TW-1:0] cnt1;
    wire [TW-1:0] rel0;
    wire [TW-1:0] rel1;
    wire [1:0] ovf;
    wire [1:0] tick;
    wire [NCH-1:0] ev;
    wire [NCH-1:0] tg;
    wire [NCH-1:0] st;
    wire [NCH-1:0] cl;
    wire [TW-1:0] chv [NCH];
    ccau_pkg::ccau_tbus_t tb;

    function automatic logic src_tick(input logic [2:0] s,
        input logic [5:0] p, input logic g, input logic e);
        logic r;
        r = 1'b0;
        case (s)
            ccau_pkg::CCAU_DIV8: r = p[2:0] == 3'h7;
            ccau_pkg::CCAU_DIV16: r = p[3:0] == 4'hf;
            ccau_pkg::CCAU_DIV32: r = p[4:0] == 5'h1f;
            ccau_pkg::CCAU_DIV64: r = p == 6'h3f;
            ccau_pkg::CCAU_GPT: r = g;
            ccau_pkg::CCAU_EXT: r = e;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    wire gpt_edge = gpt_ovf_i && !gpt_d_r;
    wire [1:0] ext_edge = ext_s2_r & ~ext_d_r;
    genvar t;
    generate
        for (t = 0; t < 2; t++)
        begin : g_tick
            assign tick[t] = tctl_r[t*ccau_pkg::TC_W + ccau_pkg::TC_RUN] &&
                stag_ok && src_tick(tctl_r[t*ccau_pkg::TC_W +
                ccau_pkg::TC_SRC_LSB +: 3], pre_r, gpt_edge, ext_edge[t]);
        end
    endgenerate

    ccau_timer #(.W(TW)) u_t0 (
        .clk_i(clk_i), .rst_i(rst_i), .tick_i(tick[0]),
        .wr_cnt_i(wr_t0), .wr_rel_i(wr_r0), .wdata_i(wb_dat_i[TW-1:0]),
        .cnt_o(cnt0), .rel_o(rel0), .ovf_o(ovf[0]));
    ccau_timer #(.W(TW)) u_t1 (
        .clk_i(clk_i), .rst_i(rst_i), .tick_i(tick[1]),
        .wr_cnt_i(wr_t1), .wr_rel_i(wr_r1), .wdata_i(wb_dat_i[TW-1:0]),
        .cnt_o(cnt1), .rel_o(rel1), .ovf_o(ovf[1]));

    assign tb.tick = tick;
    assign tb.ovf = ovf;
    assign tb.cnt0 = cnt0;
    assign tb.cnt1 = cnt1;

    genvar c;
    generate
        for (c = 0; c < NCH; c++)
        begin : g_ch
            wire wr_v = wr && in_val && ch_idx == 4'(c);
            wire arm = wr && in_mode && ch_idx == 4'(c);
            ccau_chan u_ch (
                .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_r[c]),
                .val_i(wb_dat_i[15:0]), .wr_val_i(wr_v), .arm_i(arm),
                .tb_i(tb), .pin_i(pin_s2_r[c]), .reg_o(chv[c]),
                .event_o(ev[c]), .toggle_o(tg[c]), .set_o(st[c]),
                .clr_o(cl[c]));
        end
    endgenerate

    wire [NCH-1:0] tg_all;
    generate
        for (c = 0; c < NCH; c++)
        begin : g_pair
            if (c % 2 == 0)
            begin : g_even
                assign tg_all[c] = tg[c] || (mode_r[c+1].double_en && tg[c+1]);
            end
            else
            begin : g_odd
                assign tg_all[c] = tg[c] && !mode_r[c].double_en;
            end
        end
    endgenerate

    wire [NCH-1:0] oe_nxt;
    wire [NCH-1:0] cap_ch;
    generate
        for (c = 0; c < NCH; c++)
        begin : g_oe
            wire drv = mode_r[c].func == ccau_pkg::CCAU_CMP1 ||
                mode_r[c].func == ccau_pkg::CCAU_CMP3;
            assign cap_ch[c] = mode_r[c].func == ccau_pkg::CCAU_CAP;
            // pair drives even pin unless the even channel captures, odd pin released
            if (c % 2 == 0)
            begin : g_even
                assign oe_nxt[c] = drv ||
                    (mode_r[c+1].double_en && !cap_ch[c]);
            end
            else
            begin : g_odd
                assign oe_nxt[c] = drv && !mode_r[c].double_en;
            end
        end
    endgenerate

    // Read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (wb_adr_i == ccau_pkg::A_T0)
            rd_mux = {16'h0000, cnt0};
        else if (wb_adr_i == ccau_pkg::A_T0_REL)
            rd_mux = {16'h0000, rel0};
        else if (wb_adr_i == ccau_pkg::A_T1)
            rd_mux = {16'h0000, cnt1};
        else if (wb_adr_i == ccau_pkg::A_T1_REL)
            rd_mux = {16'h0000, rel1};
        else if (wb_adr_i == ccau_pkg::A_TCTL)
            rd_mux = {16'h0000, tctl_r};
        else if (wb_adr_i == ccau_pkg::A_IRQ_STAT)
            rd_mux = 32'(stat_r);
        else if (wb_adr_i == ccau_pkg::A_IRQ_MASK)
            rd_mux = 32'(mask_r);
        else if (wb_adr_i == ccau_pkg::A_STAGGER)
            rd_mux = {31'h0, stagger_r};
        else if (in_mode)
            rd_mux = {24'h0, mode_r[ch_idx]};
        else if (in_val)
            rd_mux = {16'h0000, chv[ch_idx]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            ext_s1_r <= 2'h0;
            ext_s2_r <= 2'h0;
            ext_d_r <= 2'h0;
            gpt_d_r <= 1'b0;
            pre_r <= 6'h00;
            stag_r <= 3'h0;
        end
        else
        begin
            pin_s1_r <= pin_i;
            pin_s2_r <= pin_s1_r;
            ext_s1_r <= ext_cnt_i;
            ext_s2_r <= ext_s1_r;
            ext_d_r <= ext_s2_r;
            gpt_d_r <= gpt_ovf_i;
            pre_r <= pre_r + 6'h01;
            stag_r <= stag_r + 3'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tctl_r <= 16'h0000;
            mask_r <= '0;
            stagger_r <= 1'b0;
            for (int i = 0; i < NCH; i++)
                mode_r[i] <= ccau_pkg::ccau_mode_t'(ccau_pkg::RST_MODE);
        end
        else if (wr)
        begin
            if (wb_adr_i == ccau_pkg::A_TCTL)
                tctl_r <= wb_dat_i[15:0];
            else if (wb_adr_i == ccau_pkg::A_IRQ_MASK)
                mask_r <= wb_dat_i[NCH-1:0];
            else if (wb_adr_i == ccau_pkg::A_STAGGER)
                stagger_r <= wb_dat_i[0];
            else if (in_mode)
                mode_r[ch_idx] <= ccau_pkg::ccau_mode_t'(wb_dat_i[7:0]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stat_r <= '0;
            pin_r <= '0;
            oe_r <= '0;
            irq_r <= 1'b0;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req;
            rdat_r <= rd ? rd_mux : 32'h0000_0000;
            // events latch, new event beats read clear
            stat_r <= (rd_stat ? '0 : stat_r) | ev;
            irq_r <= |(((rd_stat ? '0 : stat_r) | ev) & mask_r);
            oe_r <= oe_nxt;
            // clear on overflow, set on match, toggle
            pin_r <= ((pin_r ^ tg_all) & ~cl) | st;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign pin_o = pin_r;
    assign pin_oe_o = oe_r;
    assign irq_o = irq_r;

    // Pin bits toggled with no set or clear, and bits cleared with no set
    wire [NCH-1:0] tg_only = tg_all & ~st & ~cl;
    wire [NCH-1:0] clr_only = cl & ~st;

    stat_set_a: assert property (@(posedge clk_i)
        disable iff (rst_i) ev[0] |=> stat_r[0])
        else $error("event not latched");
    stagger_gate_a: assert property (@(posedge clk_i)
        disable iff (rst_i) stagger_r && stag_r != 3'h7 |-> tick == 2'b00)
        else $error("tick outside stagger slot");
    ovf_clear_a: assert property (@(posedge clk_i)
        disable iff (rst_i) clr_only != '0 |=> (pin_r & $past(clr_only)) == '0)
        else $error("pin not cleared");
    toggle_inv_a: assert property (@(posedge clk_i)
        disable iff (rst_i) tg_only != '0 |=>
        ((pin_r ^ $past(pin_r)) & $past(tg_only)) == $past(tg_only))
        else $error("pin did not toggle");
    run_gate_a: assert property (@(posedge clk_i)
        disable iff (rst_i) !tctl_r[ccau_pkg::TC_RUN] |-> !tick[0])
        else $error("stopped timer ticked");
    cap_input_a: assert property (@(posedge clk_i)
        disable iff (rst_i) 1'b1 |=> (pin_oe_o & $past(cap_ch)) == '0)
        else $error("capture pin driven");
    // pins move only on an action
    pin_quiet_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (tg_all | st | cl) == '0 |=> pin_r == $past(pin_r))
        else $error("pin moved without event");
    // Interrupt follows status and mask
    irq_level_a: assert property (@(posedge clk_i)
        disable iff (rst_i) 1'b1 |=> irq_o == |(stat_r & $past(mask_r)))
        else $error("interrupt level wrong");
    // Status read clears all but new events
    stat_clr_a: assert property (@(posedge clk_i)
        disable iff (rst_i) rd_stat && ev == '0 |=> stat_r == '0)
        else $error("status not cleared");
    // Read data is zero outside ack
    rdat_idle_a: assert property (@(posedge clk_i)
        disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    // Bus answers in one cycle
    bus_ack_a: assert property (@(posedge clk_i)
        disable iff (rst_i) req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
endmodule
`default_nettype wire

// *** test/ccau_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccau_pin_model
(
    // Clock
    input wire logic clk_i,
    // Unit side of the pins
    input wire logic [15:0] pin_o_i,
    input wire logic [15:0] pin_oe_i,
    // Far side
    output logic [15:0] pin_i_o,
    output logic gpt_ovf_o,
    output logic [1:0] ext_cnt_o
);
    logic [15:0] lvl_r;
    // A pin the unit drives reads back its own level
    assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & lvl_r);
    initial
    begin
        lvl_r = 16'h0000;
        gpt_ovf_o = 1'h0;
        ext_cnt_o = 2'h0;
    end
    task automatic set_pin(input int n, input logic v);
        @(posedge clk_i);
        lvl_r[n] <= v;
    endtask
    // One count from the general timer; slow on purpose, two cycles high, then four low
    task automatic gpt_tick();
        @(posedge clk_i);
        gpt_ovf_o <= 1'h1;
        repeat (2) @(posedge clk_i);
        gpt_ovf_o <= 1'h0;
        repeat (4) @(posedge clk_i);
    endtask
    // One count on an external input, levels held across the synchroniser
    task automatic ext_tick(input int n);
        @(posedge clk_i);
        ext_cnt_o[n] <= 1'h1;
        repeat (3) @(posedge clk_i);
        ext_cnt_o[n] <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
    begin \
        num_checks++; \
        if ((a) !== (b)) \
        begin \
            mismatches++; \
            $display("[ERR] %0t got %h want %h", $time, a, b); \
        end \
    end
module tb;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [9:0] wb_adr = 10'h000;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic gpt_ovf;
    logic [1:0] ext_cnt;
    logic [15:0] pin_in;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic irq;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [15:0] v;
    logic e;
    logic hit;
    int n;

    ccau_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .gpt_ovf_i(gpt_ovf), .ext_cnt_i(ext_cnt),
        .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe), .irq_o(irq));
    ccau_pin_model u_pins (.clk_i(clk_i), .pin_o_i(pin_out),
        .pin_oe_i(pin_oe), .pin_i_o(pin_in), .gpt_ovf_o(gpt_ovf),
        .ext_cnt_o(ext_cnt));

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Whole run needs under a thousand cycles; a hang stops at 20000
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            test_done();
        end
    end

    // Classic cycle: hold until ack is seen at an edge, then release
    task automatic wb(input logic w, input logic [9:0] a,
        input logic [31:0] d);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do
            @(posedge clk_i);
        while (wb_ack !== 1'h1);
        rd = wb_rdat;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
        @(posedge clk_i);
    endtask

    function automatic logic [31:0] md(ccau_pkg::ccau_func_t f,
        logic [1:0] ed, logic t, logic s, logic d);
        return {24'h0, d, s, t, ed, f};
    endfunction

    function automatic logic [9:0] ma(int n);
        return ccau_pkg::A_CH_MODE + 10'(4 * n);
    endfunction

    function automatic logic [9:0] va(int n);
        return ccau_pkg::A_CH_VAL + 10'(4 * n);
    endfunction

    // Load timer 0 and give it one count
    task automatic hit_at(input logic [15:0] c);
        wb(1'h1, ccau_pkg::A_T0, {16'h0, c});
        u_pins.gpt_tick();
    endtask

    initial
    begin
        void'($urandom(91795));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wb(1'h0, ccau_pkg::A_T0_REL, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'h0, 10'h3fc, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'h1, ccau_pkg::A_IRQ_MASK, 32'hffff);
        wb(1'h1, ccau_pkg::A_TCTL, 32'h0909);
        // Overflow reload
        wb(1'h1, ccau_pkg::A_T0_REL, 32'hfffe);
        hit_at(16'hfffe);
        u_pins.gpt_tick();
        wb(1'h0, ccau_pkg::A_T0, 32'h0);
        `CHK(rd, 32'hfffe)
        v = 16'($urandom()) & 16'h7fff;
        // Toggle mode, then the same with the single-event option
        e = 1'h0;
        wb(1'h1, va(0), {16'h0, v});
        for (int i = 0; i < 2; i++)
        begin
            wb(1'h1, ma(0), md(ccau_pkg::CCAU_CMP1, 2'h0, 1'h0, i[0], 1'h0));
            for (int k = 0; k < 2; k++)
            begin
                hit_at(v);
                if (i == 0 || k == 0)
                    e = ~e;
                `CHK(pin_out[0], e)
                `CHK(pin_oe[0], 1'h1)
            end
        end
        wb(1'h1, ma(0), 32'h0);
        // Interrupt-only modes: 2 fires once a period, 0 each match
        wb(1'h1, va(4), {16'h0, v});
        for (int i = 0; i < 2; i++)
        begin
            wb(1'h1, ma(4), md(i ? ccau_pkg::CCAU_CMP0 : ccau_pkg::CCAU_CMP2,
                2'h0, 1'h0, 1'h0, 1'h0));
            wb(1'h0, ccau_pkg::A_IRQ_STAT, 32'h0);
            for (int k = 0; k < 2; k++)
            begin
                hit_at(v);
                hit = (i == 1 || k == 0);
                `CHK(irq, hit)
                wb(1'h0, ccau_pkg::A_IRQ_STAT, 32'h0);
                `CHK(rd, hit ? 32'h10 : 32'h0)
                `CHK(pin_out[4], 1'h0)
            end
        end
        wb(1'h1, ccau_pkg::A_IRQ_MASK, 32'h0);
        hit_at(v);
        `CHK(irq, 1'h0)
        wb(1'h0, ccau_pkg::A_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h10)
        wb(1'h1, ccau_pkg::A_IRQ_MASK, 32'hffff);
        wb(1'h1, ma(4), 32'h0);
        // Set on match, clear on overflow
        wb(1'h1, va(5), {16'h0, v});
        wb(1'h1, ma(5), md(ccau_pkg::CCAU_CMP3, 2'h0, 1'h0, 1'h0, 1'h0));
        hit_at(v);
        `CHK(pin_out[5], 1'h1)
        hit_at(16'hffff);
        `CHK(pin_out[5], 1'h0)
        // Two channels toggle one pin
        wb(1'h1, va(2), {16'h0, v});
        wb(1'h1, va(3), {16'h0, v + 16'h0064});
        wb(1'h1, ma(2), md(ccau_pkg::CCAU_CMP1, 2'h0, 1'h0, 1'h0, 1'h0));
        wb(1'h1, ma(3), md(ccau_pkg::CCAU_CMP1, 2'h0, 1'h0, 1'h0, 1'h1));
        hit_at(v);
        `CHK(pin_out[2], 1'h1)
        hit_at(v + 16'h0064);
        `CHK(pin_out[2], 1'h0)
        // Capture on the last channel from timer 1, every edge choice
        for (int ed = 1; ed < 4; ed++)
        begin
            wb(1'h1, ma(15), md(ccau_pkg::CCAU_CAP, 2'(ed), 1'h1, 1'h0, 1'h0));
            wb(1'h0, ccau_pkg::A_IRQ_STAT, 32'h0);
            for (int lv = 1; lv >= 0; lv--)
            begin
                v = 16'($urandom());
                wb(1'h1, ccau_pkg::A_T1, {16'h0, v});
                u_pins.set_pin(15, lv[0]);
                repeat (8) @(posedge clk_i);
                hit = lv ? ed[0] : ed[1];
                wb(1'h0, ccau_pkg::A_IRQ_STAT, 32'h0);
                `CHK(rd[15], hit)
                wb(1'h0, va(15), 32'h0);
                if (hit)
                    `CHK(rd[15:0], v)
            end
        end
        // Timer 0 from the /64 prescaler over 128 edges, timer 1 from pin
        wb(1'h1, ccau_pkg::A_TCTL, 32'h0b07);
        wb(1'h1, ccau_pkg::A_T1, 32'h1000);
        wb(1'h1, ccau_pkg::A_T0, 32'h0);
        repeat (126) @(posedge clk_i);
        wb(1'h0, ccau_pkg::A_T0, 32'h0);
        `CHK(rd, 32'h2)
        n = 1 + $urandom_range(7);
        repeat (n) u_pins.ext_tick(1);
        wb(1'h0, ccau_pkg::A_T1, 32'h0);
        `CHK(rd, {16'h0, 16'h1000 + 16'(n)})
        // Staggered: eight ticks seven cycles apart, one lands in the slot
        wb(1'h1, ccau_pkg::A_TCTL, 32'h0909);
        wb(1'h1, ccau_pkg::A_STAGGER, 32'h1);
        wb(1'h1, ccau_pkg::A_T0, 32'hf000);
        repeat (8) u_pins.gpt_tick();
        wb(1'h0, ccau_pkg::A_T0, 32'h0);
        `CHK(rd, {16'h0, 16'hf000 + 16'(8 / ccau_pkg::STAGGER_DIV)})
        test_done();
    end
endmodule
`default_nettype wire
